// ===== adcc_conv.v
// Control logic of a 10-bit successive-approximation converter with its register file.
// Summary of operation
// - Clock is oscillator over 2/8/32 or 4/16/64.
// - Low select bits 11 choose internal RC.
// - Channel field bits 5..3 routes that input.
// - Go bit starts, reads 1, self-clears.
// - Power bit set powers converter, clear shuts.
// - Control bit 1 always reads zero.
// - Reset leaves result registers unloaded.
// - Each conversion yields a 10-bit unsigned code.
// - One conversion clock period per bit.
// - Hold capacitor disconnects at conversion start.
// - Completion clears go, sets done flag.
// - Control runs conversion; pin config picks pins.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "adcc_map.vh"

module adcc_conv
(
    // Clock and reset.
    input  wire        clk_sys,
    input  wire        rst,
    // Register port.
    input  wire [2:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Internal RC oscillator, asynchronous to clk_sys.
    input  wire        internal_rc_clock,
    // Comparator from the analog front end, registered on clk_sys.
    input  wire        cmp_above,
    // Analog front end controls.
    output reg  [2:0]  channel_select,
    output reg         converter_power_on,
    output reg         hold_capacitor_connect,
    output reg  [9:0]  dac_trial,
    output reg  [3:0]  pin_config,
    // Completion status.
    output reg         conv_done_flag,
    output reg         conv_done_int_enable
);

    // One-hot states of the conversion sequencer.
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_CONV = 2'b10;

    // Divisor of the oscillator for a clock select code.
    function [6:0] div_of;
        input       sel_hi;
        input [1:0] sel_lo;
        begin
            case ({sel_hi, sel_lo})
                3'b000:  div_of = `ADCC_DIV_LO_00;
                3'b001:  div_of = `ADCC_DIV_LO_01;
                3'b010:  div_of = `ADCC_DIV_LO_10;
                3'b100:  div_of = `ADCC_DIV_HI_00;
                3'b101:  div_of = `ADCC_DIV_HI_01;
                3'b110:  div_of = `ADCC_DIV_HI_10;
                default: div_of = `ADCC_DIV_LO_00;
            endcase
        end
    endfunction

    // One-hot mask of a result bit position.
    function [9:0] bit_mask;
        input [3:0] idx;
        begin
            bit_mask = 10'h001 << idx;
        end
    endfunction

    // Control and configuration state.
    reg  [1:0]  clk_sel_lo;
    reg         clk_sel_hi;
    reg         right_just;
    reg         go;
    reg  [1:0]  state;
    reg  [3:0]  bit_idx;
    reg  [5:0]  div_cnt;
    reg  [9:0]  res_code;
    reg         rc_armed;

    // Synchroniser and edge detector of the RC oscillator.
    reg         rc_s1;
    reg         rc_s2;
    reg         rc_s3;

    // Decoded strobes and combinational helpers.
    wire        wr_cc;
    wire        wr_pc;
    wire        wr_ds;
    wire        start;
    wire        use_rc;
    wire        rc_tick;
    wire        div_tick;
    wire        tick;
    wire        busy;
    wire        power_next;
    wire        abort;
    wire        done_evt;
    wire [6:0]  div_now;
    wire [9:0]  decided;
    wire [7:0]  res_high;
    wire [7:0]  res_low;
    reg  [7:0]  next_rdata;

    // Address decode of writes.
    assign wr_cc = reg_wr && (reg_addr == `ADCC_OFF_CONV_CONTROL);
    assign wr_pc = reg_wr && (reg_addr == `ADCC_OFF_PIN_CONFIG);
    assign wr_ds = reg_wr && (reg_addr == `ADCC_OFF_DONE_STATUS);
    assign busy  = state[1];

    // A start needs the power bit on after this write and an idle sequencer.
    assign power_next = wr_cc ? reg_wdata[`ADCC_CC_POWER] : converter_power_on;
    assign start = wr_cc && reg_wdata[`ADCC_CC_GO] && power_next && !busy;

    // Power loss or a cleared go bit abandons a conversion without a result.
    assign abort = busy && (!power_next || (wr_cc && !reg_wdata[`ADCC_CC_GO]));

    // Conversion clock: divided oscillator or the internal RC edges.
    assign use_rc   = (clk_sel_lo == `ADCC_CLK_SEL_RC);
    assign div_now  = div_of(clk_sel_hi, clk_sel_lo);
    assign div_tick = (div_cnt == div_now[5:0] - 6'h01) ||
                      ((div_now == `ADCC_DIV_HI_10) && (div_cnt == 6'h3f));
    assign rc_tick  = rc_s2 && !rc_s3;
    // The first RC edge after a start only opens the first bit period.
    assign tick     = use_rc ? (rc_tick && rc_armed) : div_tick;

    // Keep the trial bit when the input is at or above the trial level.
    assign decided  = cmp_above ? dac_trial : (dac_trial & ~bit_mask(bit_idx));
    assign done_evt = busy && !abort && tick && (bit_idx == 4'h0);

    // Result register pair in the selected justification.
    assign res_high = right_just ? {6'h00, res_code[9:8]} : res_code[9:2];
    assign res_low  = right_just ? res_code[7:0] : {res_code[1:0], 6'h00};

    // RC oscillator synchroniser; only the second and third stages are looked at.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rc_s1 <= 1'b0;
            rc_s2 <= 1'b0;
            rc_s3 <= 1'b0;
        end
        else
        begin
            rc_s1 <= internal_rc_clock;
            rc_s2 <= rc_s1;
            rc_s3 <= rc_s2;
        end
    end

    // Software-written configuration fields.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            clk_sel_lo           <= 2'b00;
            channel_select       <= 3'h0;
            converter_power_on   <= 1'b0;
            clk_sel_hi           <= 1'b0;
            right_just           <= 1'b0;
            pin_config           <= 4'h0;
            conv_done_int_enable <= 1'b0;
        end
        else
        begin
            if (wr_cc)
            begin
                clk_sel_lo         <= reg_wdata[`ADCC_CC_CLK_LO_HI:`ADCC_CC_CLK_LO_LO];
                channel_select     <= reg_wdata[`ADCC_CC_CHAN_HI:`ADCC_CC_CHAN_LO];
                converter_power_on <= reg_wdata[`ADCC_CC_POWER];
            end
            if (wr_pc)
            begin
                clk_sel_hi <= reg_wdata[`ADCC_PC_CLK_HI];
                right_just <= reg_wdata[`ADCC_PC_RIGHT_JUST];
                pin_config <= reg_wdata[`ADCC_PC_PINS_HI:`ADCC_PC_PINS_LO];
            end
            if (wr_ds)
            begin
                conv_done_int_enable <= reg_wdata[`ADCC_DS_INT_EN];
            end
        end
    end

    // Bit period divider, restarted with each conversion so every bit gets a full period.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            div_cnt <= 6'h00;
        end
        else if (!busy || start || div_tick)
        begin
            div_cnt <= 6'h00;
        end
        else
        begin
            div_cnt <= div_cnt + 6'h01;
        end
    end

    // Successive-approximation sequencer, one decision per conversion clock period.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state                  <= ST_IDLE;
            go                     <= 1'b0;
            bit_idx                <= 4'h0;
            dac_trial              <= 10'h000;
            rc_armed               <= 1'b0;
            hold_capacitor_connect <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    hold_capacitor_connect <= power_next;
                    if (start)
                    begin
                        state                  <= ST_CONV;
                        go                     <= 1'b1;
                        bit_idx                <= 4'h9;
                        dac_trial              <= bit_mask(4'h9);
                        rc_armed               <= 1'b0;
                        hold_capacitor_connect <= 1'b0;
                    end
                end
                ST_CONV:
                begin
                    rc_armed <= rc_armed || rc_tick;
                    if (abort)
                    begin
                        state                  <= ST_IDLE;
                        go                     <= 1'b0;
                        hold_capacitor_connect <= power_next;
                    end
                    else if (tick)
                    begin
                        if (bit_idx == 4'h0)
                        begin
                            state                  <= ST_IDLE;
                            go                     <= 1'b0;
                            dac_trial              <= decided;
                            hold_capacitor_connect <= power_next;
                        end
                        else
                        begin
                            bit_idx   <= bit_idx - 4'h1;
                            dac_trial <= decided | bit_mask(bit_idx - 4'h1);
                        end
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    go    <= 1'b0;
                end
            endcase
        end
    end

    // Result code, deliberately outside reset so power-on leaves it unloaded.
    always @(posedge clk_sys)
    begin
        if (done_evt)
        begin
            res_code <= decided;
        end
    end

    // Done flag: hardware sets it, software clears it by writing zero; a set wins.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            conv_done_flag <= 1'b0;
        end
        else if (done_evt)
        begin
            conv_done_flag <= 1'b1;
        end
        else if (wr_ds && !reg_wdata[`ADCC_DS_DONE])
        begin
            conv_done_flag <= 1'b0;
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `ADCC_OFF_CONV_CONTROL:
                next_rdata = {clk_sel_lo, channel_select, go, 1'b0,
                              converter_power_on};
            `ADCC_OFF_PIN_CONFIG:
                next_rdata = {right_just, clk_sel_hi, 2'b00, pin_config};
            `ADCC_OFF_RESULT_HIGH:
                next_rdata = res_high;
            `ADCC_OFF_RESULT_LOW:
                next_rdata = res_low;
            `ADCC_OFF_DONE_STATUS:
                next_rdata = {6'h00, conv_done_int_enable, conv_done_flag};
            default:
                next_rdata = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_rd)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // adcc_conv

// ===== adcc_map.vh
// Register map, field positions, reset values and clock dividers of the converter control.
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH

// Register offsets on the plain register port.
`define ADCC_OFF_CONV_CONTROL    3'h0
`define ADCC_OFF_PIN_CONFIG      3'h1
`define ADCC_OFF_RESULT_HIGH     3'h2
`define ADCC_OFF_RESULT_LOW      3'h3
`define ADCC_OFF_DONE_STATUS     3'h4

// Field positions in conversion_control.
`define ADCC_CC_CLK_LO_HI        7
`define ADCC_CC_CLK_LO_LO        6
`define ADCC_CC_CHAN_HI          5
`define ADCC_CC_CHAN_LO          3
`define ADCC_CC_GO               2
`define ADCC_CC_POWER            0

// Field positions in pin_config_control.
`define ADCC_PC_RIGHT_JUST       7
`define ADCC_PC_CLK_HI           6
`define ADCC_PC_PINS_HI          3
`define ADCC_PC_PINS_LO          0

// Field positions in the done status register.
`define ADCC_DS_DONE             0
`define ADCC_DS_INT_EN           1

// Reset values.
`define ADCC_RST_CONV_CONTROL    8'h00
`define ADCC_RST_PIN_CONFIG      8'h00

// Result width and conversion clock divisors.
`define ADCC_RES_BITS            10
`define ADCC_DIV_LO_00           7'h02
`define ADCC_DIV_LO_01           7'h08
`define ADCC_DIV_LO_10           7'h20
`define ADCC_DIV_HI_00           7'h04
`define ADCC_DIV_HI_01           7'h10
`define ADCC_DIV_HI_10           7'h40
`define ADCC_CLK_SEL_RC          2'b11

`endif

// ===== adcc_afe_model.sv
// Behavioural analog front end: eight input levels, hold capacitor and comparator.
`timescale 1ns/1ps
module adcc_afe_model
(
    // Clock.
    input  wire        clk_sys,
    // Input levels, input 0 in the low ten bits.
    input  wire [79:0] levels,
    // Controls from the block.
    input  wire [2:0]  channel_select,
    input  wire        converter_power_on,
    input  wire        hold_capacitor_connect,
    input  wire [9:0]  dac_trial,
    // Comparator answer.
    output logic       cmp_above
);
    // Every input is taken as an analog input with its pin set to input
    logic [9:0] held;
    initial cmp_above = 1'b0;
    // The capacitor follows the routed input only while it is connected.
    always @(posedge clk_sys)
    begin
        if (hold_capacitor_connect)
            held <= levels[channel_select*10 +: 10];
    end
    // The comparator settles one cycle after the trial code and is noise while off.
    always @(posedge clk_sys)
    begin
        if (converter_power_on)
            cmp_above <= held >= dac_trial;
        else
            cmp_above <= !cmp_above;
    end
endmodule // adcc_afe_model

// ===== adcc_checker.sv
// Checker of the converter control ports.
`timescale 1ns/1ps
module adcc_checker
(
    // Clock and reset.
    input wire       clk_sys,
    input wire       rst,
    // Register port.
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Front end and status.
    input wire [2:0] channel_select,
    input wire       converter_power_on,
    input wire       hold_capacitor_connect,
    input wire [9:0] dac_trial,
    input wire [3:0] pin_config,
    input wire       conv_done_flag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // A conversion runs while powered with the capacitor cut off.
    wire       busy = converter_power_on && !hold_capacitor_connect;
    wire       wr0  = reg_wr && reg_addr == 3'h0;
    reg        sel_hi;
    reg  [1:0] sel_lo;
    reg  [9:0] cnt;
    wire [9:0] conv_bit_period = (sel_hi ? 10'h004 : 10'h002) << {sel_lo, 1'b0};
    // Shadow of the clock select and a count of busy cycles.
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sel_hi <= 1'b0;
            sel_lo <= 2'b00;
            cnt    <= 10'h000;
        end
        else
        begin
            if (reg_wr && reg_addr == 3'h1)
                sel_hi <= reg_wdata[6];
            if (wr0)
                sel_lo <= reg_wdata[7:6];
            cnt <= busy ? cnt + 10'h001 : 10'h000;
        end
    end
    a_bit_one_zero: assert property
        ($past(reg_rd && reg_addr == 3'h0) |-> !reg_rdata[1]) else $error("bit 1 read as one");
    a_chan_route: assert property
        ($past(wr0) |-> channel_select == $past(reg_wdata[5:3])) else $error("channel not routed");
    a_start_conv: assert property
        (wr0 && reg_wdata[2] && reg_wdata[0] && !busy |=> busy && dac_trial == 10'h200)
        else $error("conversion did not start");
    a_conv_time: assert property
        ($rose(conv_done_flag) && sel_lo != 2'b11 |-> cnt == 10'h00a * conv_bit_period)
        else $error("conversion length wrong");
    a_done_end: assert property
        ($rose(conv_done_flag) |-> $fell(busy) ##1 $stable(dac_trial)) else $error("done misplaced");
    a_off_no_done: assert property
        ($past(wr0 && !reg_wdata[0]) |-> !$rose(conv_done_flag)) else $error("done while off");
    a_done_clear: assert property
        ($past(reg_wr && reg_addr == 3'h4 && !reg_wdata[0] && !busy) |-> !conv_done_flag)
        else $error("done flag not cleared");
    a_pin_field: assert property
        ($past(reg_wr && reg_addr == 3'h1) |-> pin_config == $past(reg_wdata[3:0]))
        else $error("pin field not written");
    // Main scenarios: completion, refused start and abort.
    c_done: cover property ($rose(conv_done_flag));
    c_refused: cover property (wr0 && reg_wdata[2] && !reg_wdata[0]);
    c_abort: cover property ($fell(busy) && !conv_done_flag);
endmodule // adcc_checker

bind adcc_conv adcc_checker u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .channel_select, .converter_power_on, .hold_capacitor_connect, .dac_trial,
    .pin_config, .conv_done_flag);

// ===== adcc_conv_tb.sv
// Self-checking bench of the converter control with its front end model.
`timescale 1ns/1ps
module adcc_conv_tb;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        internal_rc_clock = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [79:0] levels = 80'h0;
    wire  [7:0]  reg_rdata;
    wire  [2:0]  channel_select;
    wire  [9:0]  dac_trial;
    wire  [3:0]  pin_config;
    wire         converter_power_on, hold_capacitor_connect, cmp_above;
    wire         conv_done_flag, conv_done_int_enable;
    logic [7:0]  rv, hi;
    logic [15:0] e;
    int          error_cnt = 0, compares = 0, cycles = 0, n;
    // System clock at 100 MHz and an unrelated, slower RC oscillator.
    always #5 clk_sys = ~clk_sys;
    always #37 internal_rc_clock = ~internal_rc_clock;
    adcc_conv DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .internal_rc_clock, .cmp_above, .channel_select, .converter_power_on,
        .hold_capacitor_connect, .dac_trial, .pin_config, .conv_done_flag, .conv_done_int_enable);
    adcc_afe_model u_afe (.clk_sys, .levels, .channel_select, .converter_power_on,
        .hold_capacitor_connect, .dac_trial, .cmp_above);
    // Hang guard well above the length of the run.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            error_cnt++;
            complete_run;
        end
    end
    task complete_run;
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Register writes and reads; a read returns its data in the following cycle.
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [2:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // Result pair as laid out by the justify bit.
    function automatic logic [15:0] exp_pair(input logic [9:0] r, input logic rj);
        exp_pair = rj ? {6'h00, r} : {r, 6'h00};
    endfunction
    // One conversion on input ch with the given clock code, then the result read back.
    task conv(input logic [2:0] ch, input logic hs, input logic [1:0] lo, input logic rj);
        logic [9:0] r;
        wr(3'h1, {rj, hs, 3'b000, ch});
        r = levels[ch*10 +: 10];
        wr(3'h4, 8'h02);
        wr(3'h0, {lo, ch, 3'b001});
        check({1'b0, channel_select, pin_config}, {1'b0, ch, 1'b0, ch});
        repeat (8) @(posedge clk_sys);
        wr(3'h0, {lo, ch, 3'b101});
        levels[ch*10 +: 10] <= ~r;
        rd(3'h0);
        check(rv, {lo, ch, 3'b101});
        for (n = 0; n < 1000 && rv[2] !== 1'b0; n++)
            rd(3'h0);
        check(rv, {lo, ch, 3'b001});
        rd(3'h4);
        check(rv, 8'h03);
        rd(3'h2);
        hi = rv;
        rd(3'h3);
        e = exp_pair(r, rj);
        check(hi, e[15:8]);
        check(rv, e[7:0]);
        repeat (130) @(posedge clk_sys);
    endtask
    initial
    begin
        void'($urandom(32'hbb52));
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset value, an unmapped place and a start refused while off.
        rd(3'h0);
        check(rv, 8'h00);
        wr(3'h5, 8'hff);
        rd(3'h5);
        check(rv, 8'h00);
        wr(3'h0, 8'h04);
        repeat (30) @(posedge clk_sys);
        rd(3'h0);
        check(rv, 8'h00);
        check({6'h00, hold_capacitor_connect, conv_done_flag}, 8'h00);
        // Every channel and clock code once, then random inputs.
        for (int i = 0; i < 11; i++)
        begin
            @(posedge clk_sys);
            levels <= 80'({$urandom, $urandom, $urandom});
            if (i == 0)
                levels[9:0] <= 10'h3ff;
            conv(i < 8 ? 3'(i) : 3'($urandom), 1'(i / 4), 2'(i), 1'($urandom));
        end
        // Power off in mid-conversion leaves no completion.
        wr(3'h4, 8'h00);
        wr(3'h0, 8'h85);
        repeat (40) @(posedge clk_sys);
        wr(3'h0, 8'h00);
        repeat (400) @(posedge clk_sys);
        rd(3'h4);
        check(rv, 8'h00);
        complete_run;
    end
endmodule // adcc_conv_tb
